/* File: src/spr_pkg.sv */
// Shared constants and types for the stepper phase / reset / interrupt link
package spr_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAIT_TIME_US = 1000;
  localparam int WAIT_CYCLES = (WAIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SCL_QTR_CYCLES = 25;
  localparam int STEP_CYCLES = 64;

  localparam logic [7:0] GCALL_WR_BYTE = 8'h00;
  localparam logic [7:0] RESET_CODE = 8'h06;

  localparam int FLAG_WDT_BIT = 5;
  localparam int FLAG_STOP_BIT = 4;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // Nibble i is the coil pattern of half-step index i; bit0 = D ... bit3 = A
  localparam logic [31:0] PHASE_TABLE = 32'h98C46231;
  localparam logic [2:0] FIRST_CW_IDX = 3'h0;
  localparam logic [2:0] FIRST_CCW_IDX = 3'h6;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BYTES = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_RST_PIN_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int BYTES_EXTRA_BIT = 16;
  localparam int BYTES_RSTART_BIT = 17;
  localparam logic [17:0] BYTES_RESET = 18'h00600;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  localparam int ST_INT_BIT = 3;

  typedef enum logic [1:0] {DRV_WAVE, DRV_TWO, DRV_HALF} spr_drive_type;
  typedef enum logic [2:0] {SS_IDLE, SS_ADDR, SS_DATA, SS_ARMED, SS_IGNORE} spr_slv_state_type;
  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BITS, MS_RSTART, MS_STOP, MS_WAIT}
    spr_mst_state_type;
endpackage : spr_pkg

/* File: src/spr_link_if.sv */
// Serial bus, reset pin and interrupt line joining controller and device
`timescale 1ns/1ps
interface spr_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic reset_pin_n;
  logic int_o;
  logic int_oe_n;
  wire scl;
  wire sda;
  wire int_line_n;

  // Open-drain wires: pulled up unless an enabled driver pulls low
  assign scl = !(!scl_oe_n && !scl_o);
  assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_d_oe_n && !sda_d_o));
  assign int_line_n = !(!int_oe_n && !int_o);

  modport master (
    output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n, reset_pin_n,
    input scl, sda, int_line_n
  );
  modport device (
    output sda_d_o, sda_d_oe_n, int_o, int_oe_n,
    input scl, sda, reset_pin_n
  );
endinterface : spr_link_if

/* File: src/spr_device.sv */
// Device end: bus reset call, reset pin, interrupt line, coil phase generator
`timescale 1ns/1ps
// Behaviour
// - Reset pin low holds everything but the general I/O outputs at defaults
// - Master waits 1 ms after pin release
// - Master waits 1 ms after bus reset
// - Acknowledge general call write 00h only
// - Acknowledge data byte only when 06h
// - No acknowledge for further data bytes
// - STOP after acknowledged code resets all
// - Repeated START after code cancels reset
// - Master treats any missing acknowledge as abort
// - Open-drain low interrupt from three sources
// - Enabled watchdog timeout sets flag bit 5
// - Unmasked run bit fall sets flag 4
// - Pin interrupt needs input, unmasked, selected edge
// - Disable bit high blocks interrupt pin
// - Output-to-input switch may give false interrupt
// - Wave drive one coil, order D C B A
// - Two-phase drive DC, CB, BA, AD; first run after reset starts on single coil D (A when ccw)
// - Half step interleaves single and paired coils
// - Data change with clock high is control
// - Data fall is START, rise is STOP
// - Master starts only on idle bus
// - Restart energizes the pattern where stopped
module spr_device (
  input wire logic pclk,
  input wire logic presetn,
  spr_link_if.device link,
  input wire logic run_bit,
  input wire logic ccw,
  input wire spr_pkg::spr_drive_type drive_mode,
  input wire logic wdt_enable,
  input wire logic wdt_timeout,
  input wire logic [7:0] interrupt_mask_reg,
  input wire logic [3:0] edge_select_reg,
  input wire logic [3:0] io_is_input,
  input wire logic [3:0] io_out_val,
  input wire logic int_disable,
  input wire logic [7:0] flag_clear,
  input wire logic [3:0] general_io_lines_in,
  output logic [3:0] general_io_lines_o,
  output logic [3:0] general_io_lines_oe_n,
  output logic [3:0] coil_drive,
  output logic [7:0] interrupt_flag_reg,
  output logic regs_reset_pulse
);
  import spr_pkg::*;

  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic rstp_s1_ff, rstp_s2_ff;
  logic [3:0] gio_s1_ff, gio_s2_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic hold_clear, bus_reset_call_ff, ack_now;
  spr_slv_state_type state_ff, nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic ack_phase_ff, acked_ff, sda_low_ff, int_oe_n_ff;
  logic [2:0] idx_ff, start_idx, nxt_idx;
  logic first_run_ff, run_d_ff;
  logic [7:0] step_cnt_ff;
  logic [3:0] in_port_ff, gio_edge;
  logic [7:0] flag_set, flag_enabled;

  function automatic logic [2:0] align_idx(input logic [2:0] i, input spr_drive_type m);
    case (m)
      DRV_WAVE: align_idx = {i[2:1], 1'b0};
      DRV_TWO: align_idx = {i[2:1], 1'b1};
      default: align_idx = i;
    endcase
  endfunction : align_idx

  function automatic logic [3:0] pattern_of(input logic [2:0] i);
    pattern_of = PHASE_TABLE[{i, 2'b00} +: 4];
  endfunction : pattern_of

  // Every pin-side input passes two flops before any logic reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
      rstp_s1_ff <= 1'b1;
      rstp_s2_ff <= 1'b1;
      gio_s1_ff <= 4'h0;
      gio_s2_ff <= 4'h0;
    end else begin
      scl_s1_ff <= link.scl;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= link.sda;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      rstp_s1_ff <= link.reset_pin_n;
      rstp_s2_ff <= rstp_s1_ff;
      gio_s1_ff <= general_io_lines_in;
      gio_s2_ff <= gio_s1_ff;
    end
  end

  assign scl_rise = scl_s2_ff && !scl_s3_ff;
  assign scl_fall = !scl_s2_ff && scl_s3_ff;
  assign start_det = scl_s2_ff && scl_s3_ff && !sda_s2_ff && sda_s3_ff;
  assign stop_det = scl_s2_ff && scl_s3_ff && sda_s2_ff && !sda_s3_ff;
  assign hold_clear = !rstp_s2_ff || bus_reset_call_ff;

  assign ack_now = (state_ff == SS_ADDR && shift_ff == GCALL_WR_BYTE) ||
                   (state_ff == SS_DATA && shift_ff == RESET_CODE);

  always_comb begin
    case (state_ff)
      SS_ADDR: nxt_state = acked_ff ? SS_DATA : SS_IGNORE;
      SS_DATA: nxt_state = acked_ff ? SS_ARMED : SS_IGNORE;
      default: nxt_state = SS_IGNORE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SS_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_phase_ff <= 1'b0;
      acked_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (hold_clear) begin
      state_ff <= SS_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_phase_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= SS_ADDR;
      bit_cnt_ff <= 4'h0;
      ack_phase_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= SS_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_phase_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (scl_rise && state_ff != SS_IDLE && bit_cnt_ff < 4'h8) begin
      shift_ff <= {shift_ff[6:0], sda_s2_ff};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (scl_fall && ack_phase_ff) begin
      ack_phase_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      state_ff <= nxt_state;
    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
      // Drive the ack only after clock low, so data never moves with clock high
      ack_phase_ff <= 1'b1;
      sda_low_ff <= ack_now;
      acked_ff <= ack_now;
    end
  end

  // A STOP always follows one clock rise that samples a bit; more bits mean a cut byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reset_call_ff <= 1'b0;
    end else begin
      bus_reset_call_ff <= stop_det && !hold_clear && state_ff == SS_ARMED &&
                  bit_cnt_ff < 4'h2;
    end
  end

  always_comb begin
    start_idx = first_run_ff ? (ccw ? FIRST_CCW_IDX : FIRST_CW_IDX)
                             : align_idx(idx_ff, drive_mode);
    if (drive_mode == DRV_HALF) begin
      nxt_idx = ccw ? idx_ff - 3'h1 : idx_ff + 3'h1;
    end else begin
      nxt_idx = ccw ? idx_ff - 3'h2 : idx_ff + 3'h2;
    end
    nxt_idx = align_idx(nxt_idx, drive_mode);
  end

  // Coils hold the last pattern while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 3'h0;
      first_run_ff <= 1'b1;
      run_d_ff <= 1'b0;
      step_cnt_ff <= 8'h00;
      coil_drive <= 4'h0;
    end else if (hold_clear) begin
      idx_ff <= 3'h0;
      first_run_ff <= 1'b1;
      run_d_ff <= 1'b0;
      step_cnt_ff <= 8'h00;
      coil_drive <= 4'h0;
    end else begin
      run_d_ff <= run_bit;
      if (run_bit && !run_d_ff) begin
        idx_ff <= start_idx;
        coil_drive <= pattern_of(start_idx);
        first_run_ff <= 1'b0;
        step_cnt_ff <= 8'h00;
      end else if (run_bit) begin
        if (step_cnt_ff == 8'(STEP_CYCLES - 1)) begin
          step_cnt_ff <= 8'h00;
          idx_ff <= nxt_idx;
          coil_drive <= pattern_of(nxt_idx);
        end else begin
          step_cnt_ff <= step_cnt_ff + 8'h01;
        end
      end
    end
  end

  // Stored input level is stale while a pin is an output, hence the false edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gio
      assign gio_edge[gi] = io_is_input[gi] && !interrupt_mask_reg[gi] &&
        (edge_select_reg[gi] ? (in_port_ff[gi] && !gio_s2_ff[gi])
                             : (!in_port_ff[gi] && gio_s2_ff[gi]));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_port_ff[gi] <= 1'b0;
        end else if (hold_clear) begin
          in_port_ff[gi] <= 1'b0;
        end else if (io_is_input[gi]) begin
          in_port_ff[gi] <= gio_s2_ff[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG_WDT_BIT] = wdt_enable && wdt_timeout;
    flag_enabled = {2'b00, 1'b1, ~interrupt_mask_reg[4:0]};
    flag_set[FLAG_STOP_BIT] = run_d_ff && !run_bit && flag_enabled[FLAG_STOP_BIT];
    flag_set[3:0] = gio_edge;
  end

  // A set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_flag_reg <= FLAG_RESET;
      int_oe_n_ff <= 1'b1;
    end else if (hold_clear) begin
      interrupt_flag_reg <= FLAG_RESET;
      int_oe_n_ff <= 1'b1;
    end else begin
      interrupt_flag_reg <= (interrupt_flag_reg & ~flag_clear) | flag_set;
      int_oe_n_ff <= !(|(interrupt_flag_reg & flag_enabled) && !int_disable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_io_lines_o <= 4'h0;
      general_io_lines_oe_n <= 4'hF;
      regs_reset_pulse <= 1'b0;
    end else begin
      general_io_lines_o <= io_out_val;
      general_io_lines_oe_n <= io_is_input;
      regs_reset_pulse <= bus_reset_call_ff;
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe_n = !sda_low_ff;
  assign link.int_o = 1'b0;
  assign link.int_oe_n = int_oe_n_ff;
endmodule : spr_device

/* File: src/spr_master.sv */
// Controller end: APB registers, reset pin and bus reset call sequencer
`timescale 1ns/1ps
module spr_master #(
  parameter int WAIT_CYCLES_P = spr_pkg::WAIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spr_link_if.master link
);
  import spr_pkg::*;

  logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff, int_s1_ff, int_s2_ff;
  logic ctrl_rst_ff, rst_d_ff, reset_pin_n_ff;
  logic [17:0] bytes_ff;
  logic done_ff, abort_ff, seq_end_ff, abort_set_ff, no_wait_ff, ack_ok_ff;
  logic scl_low_ff, sda_low_ff, tick, wr_en, setup, mapped, go;
  spr_mst_state_type state_ff;
  logic [4:0] div_ff;
  logic [1:0] qtr_ff, byte_ff;
  logic [3:0] bit_ff;
  logic [31:0] wait_ff, rd_mux;
  logic [7:0] cur_byte;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      int_s1_ff <= 1'b1;
      int_s2_ff <= 1'b1;
    end else begin
      scl_s1_ff <= link.scl;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= link.sda;
      sda_s2_ff <= sda_s1_ff;
      int_s1_ff <= link.int_line_n;
      int_s2_ff <= int_s1_ff;
    end
  end

  // Zero-wait slave: pready rises in the first access cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign mapped = paddr == REG_CTRL || paddr == REG_BYTES || paddr == REG_STATUS;
  assign go = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_mux[CTRL_RST_PIN_BIT] = ctrl_rst_ff;
      REG_BYTES: rd_mux[17:0] = bytes_ff;
      REG_STATUS: begin
        rd_mux[ST_BUSY_BIT] = state_ff != MS_IDLE;
        rd_mux[ST_DONE_BIT] = done_ff;
        rd_mux[ST_ABORT_BIT] = abort_ff;
        rd_mux[ST_INT_BIT] = !int_s2_ff;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_rst_ff <= 1'b0;
      rst_d_ff <= 1'b0;
      reset_pin_n_ff <= 1'b1;
      bytes_ff <= BYTES_RESET;
    end else begin
      if (wr_en && paddr == REG_CTRL) ctrl_rst_ff <= pwdata[CTRL_RST_PIN_BIT];
      if (wr_en && paddr == REG_BYTES) bytes_ff <= pwdata[17:0];
      rst_d_ff <= ctrl_rst_ff;
      reset_pin_n_ff <= !ctrl_rst_ff;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      done_ff <= seq_end_ff ||
                 (done_ff && !(wr_en && paddr == REG_STATUS && pwdata[ST_DONE_BIT]));
      abort_ff <= abort_set_ff ||
                  (abort_ff && !(wr_en && paddr == REG_STATUS && pwdata[ST_ABORT_BIT]));
    end
  end

  assign tick = div_ff == 5'(SCL_QTR_CYCLES - 1);
  assign cur_byte = (byte_ff == 2'h0) ? bytes_ff[7:0] : bytes_ff[15:8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MS_IDLE;
      div_ff <= 5'h00;
      qtr_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      wait_ff <= 32'h0000_0000;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      no_wait_ff <= 1'b0;
      seq_end_ff <= 1'b0;
      abort_set_ff <= 1'b0;
    end else begin
      seq_end_ff <= 1'b0;
      abort_set_ff <= 1'b0;
      div_ff <= (tick || state_ff == MS_IDLE || state_ff == MS_WAIT) ? 5'h00 : div_ff + 5'h01;
      if (tick) qtr_ff <= qtr_ff + 2'h1;
      case (state_ff)
        MS_IDLE: begin
          qtr_ff <= 2'h0;
          if (rst_d_ff && !ctrl_rst_ff) begin
            state_ff <= MS_WAIT;
            wait_ff <= 32'h0000_0000;
          end else if (go && !ctrl_rst_ff && scl_s2_ff && sda_s2_ff) begin
            state_ff <= MS_START;
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            no_wait_ff <= 1'b0;
          end
        end
        MS_WAIT: begin
          wait_ff <= wait_ff + 32'h0000_0001;
          if (wait_ff == 32'(WAIT_CYCLES_P - 1)) state_ff <= MS_IDLE;
        end
        MS_START: if (tick) begin
          if (qtr_ff == 2'h1) sda_low_ff <= 1'b1;
          if (qtr_ff == 2'h2) scl_low_ff <= 1'b1;
          if (qtr_ff == 2'h3) state_ff <= MS_BITS;
        end
        MS_BITS: if (tick) begin
          case (qtr_ff)
            2'h0: sda_low_ff <= (bit_ff < 4'h8) ? !cur_byte[3'(4'h7 - bit_ff)] : 1'b0;
            2'h1: scl_low_ff <= 1'b0;
            2'h2: if (bit_ff == 4'h8) ack_ok_ff <= !sda_s2_ff;
            default: begin
              scl_low_ff <= 1'b1;
              if (bit_ff != 4'h8) begin
                bit_ff <= bit_ff + 4'h1;
              end else begin
                bit_ff <= 4'h0;
                if (!ack_ok_ff) begin
                  abort_set_ff <= 1'b1;
                  no_wait_ff <= 1'b1;
                  state_ff <= MS_STOP;
                end else if (byte_ff == {1'b0, 1'b1} + {1'b0, bytes_ff[BYTES_EXTRA_BIT]}) begin
                  state_ff <= bytes_ff[BYTES_RSTART_BIT] ? MS_RSTART : MS_STOP;
                  no_wait_ff <= bytes_ff[BYTES_RSTART_BIT];
                end else begin
                  byte_ff <= byte_ff + 2'h1;
                end
              end
            end
          endcase
        end
        MS_RSTART: if (tick) begin
          if (qtr_ff == 2'h0) sda_low_ff <= 1'b0;
          if (qtr_ff == 2'h1) scl_low_ff <= 1'b0;
          if (qtr_ff == 2'h2) sda_low_ff <= 1'b1;
          if (qtr_ff == 2'h3) begin
            scl_low_ff <= 1'b1;
            state_ff <= MS_STOP;
          end
        end
        MS_STOP: if (tick) begin
          if (qtr_ff == 2'h0) sda_low_ff <= 1'b1;
          if (qtr_ff == 2'h1) scl_low_ff <= 1'b0;
          if (qtr_ff == 2'h2) sda_low_ff <= 1'b0;
          if (qtr_ff == 2'h3) begin
            seq_end_ff <= 1'b1;
            wait_ff <= 32'h0000_0000;
            state_ff <= no_wait_ff ? MS_IDLE : MS_WAIT;
          end
        end
        default: state_ff <= MS_IDLE;
      endcase
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = !scl_low_ff;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe_n = !sda_low_ff;
  assign link.reset_pin_n = reset_pin_n_ff;
endmodule : spr_master

/* File: verif/spr_link_assertions.sv */
// Wire-level checks on the serial link, reset pin and interrupt line
`timescale 1ns/1ps
module spr_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_line_n,
  input wire logic sda_d_oe_n,
  input wire logic int_oe_n,
  input wire logic int_o,
  input wire logic reset_pin_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ack_hold;
    (!sda_d_oe_n) [*8];
  endsequence
  sequence s_bus_idle;
    (scl && sda) [*8];
  endsequence
  AST_DEV_SDA_STABLE: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
    else $error("device moved sda while scl high");
  AST_ACK_LOW_SCL: assert property ($fell(sda_d_oe_n) |-> !scl)
    else $error("device ack started with scl high");
  AST_ACK_HOLD: assert property ($rose(scl) && !sda_d_oe_n |-> s_ack_hold)
    else $error("device ack dropped during clock high");
  AST_ACK_ONE_BIT: assert property ($fell(sda_d_oe_n) |-> ##[90:110] $rose(sda_d_oe_n))
    else $error("device ack not one bit long");
  AST_PIN_RESET: assert property (!reset_pin_n [*4] |-> sda_d_oe_n && int_oe_n)
    else $error("device active while reset pin low");
  AST_START_FRAME: assert property (scl && $fell(sda) |-> ##[20:30] !scl)
    else $error("no clock low after start");
  AST_STOP_IDLE: assert property (scl && $rose(sda) |-> s_bus_idle)
    else $error("bus not idle after stop");
  AST_INT_OPEN_DRAIN: assert property (!int_oe_n |-> !int_o && !int_line_n)
    else $error("interrupt line not pulled low");
endmodule : spr_link_assertions

/* File: verif/tb.sv */
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module tb;
  import spr_pkg::*;
  typedef struct packed {logic [31:0] bytes; logic [31:0] st; logic [7:0] fl;} spr_row_type;
  logic pclk = 0;
  logic presetn = 0;
  logic [7:0] paddr = '0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_bit = 0;
  logic ccw = 0;
  logic wdt_timeout = 0;
  logic int_disable = 0;
  spr_drive_type drive_mode = DRV_HALF;
  logic [7:0] int_mask = 8'h08;
  logic [7:0] flag_clear = '0;
  logic [3:0] gp_in = '0;
  logic [3:0] io_in = 4'hF;
  logic wdt_en = 1'b1;
  logic [3:0] gp_o;
  logic [3:0] gp_oe_n;
  logic [3:0] coil_drive;
  logic [7:0] flags;
  logic rst_pulse;
  logic [31:0] rd;
  logic er;
  logic [3:0] exp_tbl [8];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int rst_seen = 0;
  spr_row_type rows [5] = '{'{32'h00000600, 32'h00000002, 8'h00},
    '{32'h00000601, 32'h0000000E, 8'h20}, '{32'h00000700, 32'h0000000E, 8'h20},
    '{32'h00010600, 32'h0000000E, 8'h20}, '{32'h00020600, 32'h0000000A, 8'h20}};
  spr_link_if spr_link_if_inst ();
  spr_master #(.WAIT_CYCLES_P(50)) spr_master_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(spr_link_if_inst));
  spr_device spr_device_inst (.pclk(pclk), .presetn(presetn), .link(spr_link_if_inst),
    .run_bit(run_bit), .ccw(ccw), .drive_mode(drive_mode), .wdt_enable(wdt_en),
    .wdt_timeout(wdt_timeout), .interrupt_mask_reg(int_mask), .edge_select_reg(4'h1),
    .io_is_input(io_in), .io_out_val(4'hA), .int_disable(int_disable), .flag_clear(flag_clear),
    .general_io_lines_in(gp_in), .general_io_lines_o(gp_o), .general_io_lines_oe_n(gp_oe_n),
    .coil_drive(coil_drive), .interrupt_flag_reg(flags), .regs_reset_pulse(rst_pulse));
  spr_link_assertions spr_link_assertions_inst (.pclk(pclk), .presetn(presetn),
    .scl(spr_link_if_inst.scl), .sda(spr_link_if_inst.sda),
    .int_line_n(spr_link_if_inst.int_line_n), .sda_d_oe_n(spr_link_if_inst.sda_d_oe_n),
    .int_oe_n(spr_link_if_inst.int_oe_n), .int_o(spr_link_if_inst.int_o),
    .reset_pin_n(spr_link_if_inst.reset_pin_n));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task wrap_up;
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // One idle cycle after each transfer so strobes are never reassigned in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task pulse(input int what);
    if (what == 0) wdt_timeout <= 1'b1;
    else flag_clear <= 8'hFF;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    flag_clear <= 8'h00;
    repeat (4) @(posedge pclk);
  endtask : pulse
  // Samples mid-step; the first pattern must sit at table position st
  task run_chk(input int len, input int dir, input int st, input int n);
    int j;
    j = 9;
    run_bit <= 1'b1;
    repeat (33) @(posedge pclk);
    for (int k = 0; k < len; k++) if (exp_tbl[k] === coil_drive) j = k;
    chk(32'(st), 32'(j));
    for (int s = 0; s < n; s++) begin
      chk(32'(exp_tbl[j % len]), 32'(coil_drive));
      if (s < n - 1) begin
        j = (j + dir + len) % len;
        repeat (64) @(posedge pclk);
      end
    end
    run_bit <= 1'b0;
    @(posedge pclk);
  endtask : run_chk
  always @(posedge pclk) begin
    cyc++;
    if (rst_pulse === 1'b1) rst_seen++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    exp_tbl = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
    run_chk(8, 1, 0, 8);
    repeat (3) @(posedge pclk);
    chk(8'h10, flags);
    chk(0, spr_link_if_inst.int_line_n);
    int_disable <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(1, spr_link_if_inst.int_line_n);
    int_disable <= 1'b0;
    pulse(1);
    chk(1, spr_link_if_inst.int_line_n);
    ccw <= 1'b1;
    run_chk(8, -1, 7, 8);
    exp_tbl = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4, 4'h8};
    ccw <= 1'b0;
    drive_mode <= DRV_WAVE;
    run_chk(4, 1, 0, 5);
    exp_tbl = '{4'h3, 4'h6, 4'hC, 4'h9, 4'h3, 4'h6, 4'hC, 4'h9};
    drive_mode <= DRV_TWO;
    run_chk(4, 1, 0, 5);
    pulse(1);
    gp_in <= 4'hF;
    repeat (6) @(posedge pclk);
    chk(8'h06, flags);
    gp_in <= 4'h0;
    repeat (6) @(posedge pclk);
    chk(8'h07, flags);
    pulse(1);
    // Pins as outputs ignore their level; turning them back to inputs trips the stale compare
    io_in <= 4'h0;
    gp_in <= 4'hF;
    repeat (6) @(posedge pclk);
    chk(8'h00, flags);
    chk(4'h0, gp_oe_n);
    chk(4'hA, gp_o);
    io_in <= 4'hF;
    repeat (3) @(posedge pclk);
    chk(8'h06, flags);
    gp_in <= 4'h0;
    wdt_en <= 1'b0;
    repeat (6) @(posedge pclk);
    pulse(1);
    pulse(0);
    chk(8'h00, flags);
    wdt_en <= 1'b1;
    foreach (rows[i]) begin
      pulse(0);
      apb(1'b1, REG_BYTES, rows[i].bytes);
      rst_seen = 0;
      apb(1'b1, REG_CTRL, 32'h00000002);
      for (int n = 0; n < 3000 && rd[1:0] !== 2'b10; n++) apb(1'b0, REG_STATUS, 32'h0);
      chk(rows[i].st, rd);
      chk(rows[i].fl, flags);
      chk(rows[i].fl == 8'h00, rst_seen);
      apb(1'b1, REG_STATUS, 32'h00000006);
      pulse(1);
    end
    pulse(0);
    apb(1'b1, REG_CTRL, 32'h00000001);
    repeat (8) @(posedge pclk);
    chk(8'h00, flags);
    pulse(0);
    chk(8'h00, flags);
    apb(1'b1, REG_CTRL, 32'h00000000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(1, rd[0]);
    apb(1'b0, 8'h0C, 32'h0);
    chk(1, er);
    wrap_up;
  end
endmodule : tb
